// *** verilog/uart_rx_pkg.sv ***
/*
 * constants and types shared by the debug uart receive path.
 * assumes a single 50 MHz system clock and a synchronous active-low reset.
 */
package uart_rx_pkg;

   // ****************************************************************
   // widths and fifo depth
   // ****************************************************************
   localparam int DIV_W       = 17;
   localparam int DATA_W      = 8;
   localparam int STREAM_W    = DATA_W + 2;
   localparam int FIFO_DEPTH  = 8;
   localparam int OS_CNT_W    = 5;
   localparam int BIT_CNT_W   = 4;

   // ****************************************************************
   // oversampling timing in sampling-clock ticks, and bit-counter indices
   // ****************************************************************
   localparam int OS_PER_BIT        = 16;
   localparam int START_MIN_LOW     = 7;
   localparam int FIRST_SAMPLE      = 24;
   localparam int SAMPLE_RESTART    = FIRST_SAMPLE - OS_PER_BIT;
   localparam logic [OS_CNT_W-1:0]  START_LAST_CNT  = OS_CNT_W'(START_MIN_LOW - 1);
   localparam logic [OS_CNT_W-1:0]  SAMPLE_LAST_CNT = OS_CNT_W'(FIRST_SAMPLE - 1);
   localparam logic [OS_CNT_W-1:0]  SAMPLE_RELOAD   = OS_CNT_W'(SAMPLE_RESTART);
   localparam logic [BIT_CNT_W-1:0] PARITY_IDX      = BIT_CNT_W'(DATA_W);
   localparam logic [BIT_CNT_W-1:0] STOP_IDX_NOPAR  = BIT_CNT_W'(DATA_W);
   localparam logic [BIT_CNT_W-1:0] STOP_IDX_PAR    = BIT_CNT_W'(DATA_W + 1);

   // ****************************************************************
   // parity type field codes
   // ****************************************************************
   localparam logic [2:0] PAR_EVEN  = 3'h0;
   localparam logic [2:0] PAR_ODD   = 3'h1;
   localparam logic [2:0] PAR_SPACE = 3'h2;
   localparam logic [2:0] PAR_MARK  = 3'h3;
   localparam logic [2:0] PAR_NONE  = 3'h4;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [DATA_W-1:0]   HOLD_RESET    = 8'h00;
   localparam logic                LINE_IDLE     = 1'b1;
   localparam logic [DIV_W-1:0]    DIV_CNT_RESET = 17'h00001;

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_HUNT = 3'b010,
      ST_RECV = 3'b100
   } rx_state_t;

endpackage

// *** verilog/os_tick_gen.sv ***
/*
 * sampling-clock tick generator: one-cycle pulse every divisor clocks.
 * assumes the divisor comes from logic on the same clock.
 */
`timescale 1ns/1ps
module os_tick_gen (
   input  wire logic                           sys_clk_in,
   input  wire logic                           resetn_in,
   input  wire logic [uart_rx_pkg::DIV_W-1:0]  divisor_in,
   output logic                                tick_out
);
   import uart_rx_pkg::*;

   logic [DIV_W-1:0] div_cnt;
   wire              div_off  = (divisor_in == '0);
   wire              div_wrap = (div_cnt >= divisor_in);

   // ****************************************************************
   // divider
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || div_off) begin
         div_cnt  <= DIV_CNT_RESET;
         tick_out <= 1'b0;
      end else if (div_wrap) begin
         div_cnt  <= DIV_CNT_RESET;
         tick_out <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + DIV_W'(1);
         tick_out <= 1'b0;
      end
   end

endmodule

// *** verilog/char_fifo.sv ***
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock; width and depth shape the storage.
 */
`timescale 1ns/1ps
module char_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk_in,
   input  wire logic             resetn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;

   wire              push       = in_valid_in && in_ready_out;
   wire              pop        = out_valid_out && out_ready_in;
   wire [CW-1:0]     next_count = count + CW'(push) - CW'(pop);
   wire [PW-1:0]     next_rd    = pop ? PW'(rd_ptr + PW'(1)) : rd_ptr;

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         wr_ptr        <= '0;
         rd_ptr        <= '0;
         count         <= '0;
         in_ready_out  <= 1'b1;
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else begin
         wr_ptr        <= push ? PW'(wr_ptr + PW'(1)) : wr_ptr;
         rd_ptr        <= next_rd;
         // registered head; a push into an emptied fifo passes straight through
         out_data_out  <= (push && wr_ptr == next_rd) ? in_data_in : mem[next_rd];
         count         <= next_count;
         in_ready_out  <= (next_count != CW'(DEPTH));
         out_valid_out <= (next_count != '0);
      end
   end

endmodule

// *** verilog/debug_uart_receiver.sv ***
/*
 * receive path of the two-pin debug uart with its baud divider,
 * receive holding register, status flags and debug channel status.
 * assumes command inputs are one-cycle pulses from logic on sys_clk_in;
 * the serial line and the debug channel pending levels are asynchronous.
 */
`timescale 1ns/1ps

// Functional notes
// - sampling tick is clock over divisor
// - zero divisor stops tick, uart stays inactive
// - divisor accepts 1 through 131071
// - asynchronous only, 8 data bits, optional parity
// - receiver off after reset until enabled
// - disable: stop now if hunting, else finish
// - reset command aborts character, disables receiver
// - start needs low longer than 7 ticks
// - first sample at 24, then every 16
// - completed character loads holding, sets ready
// - holding read clears ready flag
// - character while ready set raises overrun
// - overrun cleared by status reset command
// - parity mismatch sets parity error with ready
// - parity error sticky until status reset
// - even, odd, mark, space parity
// - debug channel pending bits visible, interrupting
// - zero stop bit sets sticky framing error
module debug_uart_receiver (
   input  wire logic                                sys_clk_in,
   input  wire logic                                resetn_in,
   input  wire logic                                debug_rx_line_in,
   input  wire logic [uart_rx_pkg::DIV_W-1:0]       clock_divisor_in,
   input  wire logic [2:0]                          parity_type_field_in,
   input  wire logic                                rx_enable_cmd_in,
   input  wire logic                                rx_disable_cmd_in,
   input  wire logic                                rx_reset_cmd_in,
   input  wire logic                                status_reset_cmd_in,
   input  wire logic                                rx_holding_read_in,
   input  wire logic                                dcc_read_pending_in,
   input  wire logic                                dcc_write_pending_in,
   input  wire logic [1:0]                          dcc_irq_mask_in,
   input  wire logic                                rx_stream_ready_in,
   output logic      [uart_rx_pkg::DATA_W-1:0]      rx_holding_reg_out,
   output logic                                     rx_ready_flag_out,
   output logic                                     overrun_flag_out,
   output logic                                     parity_error_flag_out,
   output logic                                     framing_error_flag_out,
   output logic                                     rx_enabled_out,
   output logic                                     rx_busy_out,
   output logic                                     dcc_read_pending_out,
   output logic                                     dcc_write_pending_out,
   output logic                                     dcc_irq_out,
   output logic                                     rx_fifo_ready_out,
   output logic                                     rx_stream_valid_out,
   output logic      [uart_rx_pkg::STREAM_W-1:0]    rx_stream_data_out
);
   import uart_rx_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   rx_state_t               state;
   rx_state_t               next_state;
   logic                    rx_meta;
   logic                    rx_sync;
   logic [1:0]              dcc_meta;
   logic [1:0]              dcc_sync;
   logic                    os_tick;
   logic                    low_seen;
   logic [OS_CNT_W-1:0]     os_cnt;
   logic [BIT_CNT_W-1:0]    bit_cnt;
   logic [DATA_W-1:0]       shift;
   logic                    par_bit;
   logic                    disable_pending;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   // the first stage of each pair feeds only the second stage
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         rx_meta <= LINE_IDLE;
         rx_sync <= LINE_IDLE;
      end else begin
         rx_meta <= debug_rx_line_in;
         rx_sync <= rx_meta;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         dcc_meta <= 2'h0;
         dcc_sync <= 2'h0;
      end else begin
         dcc_meta <= {dcc_write_pending_in, dcc_read_pending_in};
         dcc_sync <= dcc_meta;
      end
   end

   // ****************************************************************
   // oversampling tick
   // ****************************************************************
   os_tick_gen u_tick (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .divisor_in (clock_divisor_in),
      .tick_out   (os_tick)
   );

   // ****************************************************************
   // decode
   // ****************************************************************
   wire line_low   = !rx_sync;
   wire in_hunt    = (state == ST_HUNT);
   wire in_recv    = (state == ST_RECV);
   wire par_en     = !parity_type_field_in[2];
   wire [BIT_CNT_W-1:0] stop_idx = par_en ? STOP_IDX_PAR : STOP_IDX_NOPAR;

   // eight low ticks in a row, counting the edge tick, beat the 7-tick floor
   wire start_ok   = in_hunt && os_tick && line_low && low_seen
                     && (os_cnt == START_LAST_CNT);
   wire sample_now = in_recv && os_tick && (os_cnt == SAMPLE_LAST_CNT);
   wire data_slot  = sample_now && (bit_cnt < PARITY_IDX);
   wire par_slot   = sample_now && par_en && (bit_cnt == PARITY_IDX);
   wire char_done  = sample_now && (bit_cnt == stop_idx);
   wire stop_bad   = char_done && !rx_sync;

   // ****************************************************************
   // parity
   // ****************************************************************
   wire data_xor   = ^shift;
   wire par_expect = (parity_type_field_in == PAR_EVEN)  ? data_xor  :
                     (parity_type_field_in == PAR_ODD)   ? !data_xor :
                     (parity_type_field_in == PAR_MARK)  ? 1'b1      :
                     1'b0;
   wire par_bad    = char_done && par_en && (par_bit != par_expect);

   // ****************************************************************
   // flag updates
   // ****************************************************************
   // a set in the same cycle as a status reset wins over the clear
   wire set_ready  = char_done;
   wire set_ovr    = char_done && rx_ready_flag_out && !rx_holding_read_in;
   wire next_ready = set_ready || (rx_ready_flag_out && !rx_holding_read_in);
   wire next_ovr   = set_ovr || (overrun_flag_out && !status_reset_cmd_in);
   wire next_parity_error_flag  = par_bad || (parity_error_flag_out && !status_reset_cmd_in);
   wire next_frame = stop_bad || (framing_error_flag_out && !status_reset_cmd_in);

   // ****************************************************************
   // receiver state machine
   // ****************************************************************
   always_comb begin
      next_state = state;
      if (rx_reset_cmd_in) begin
         next_state = ST_OFF;
      end else begin
         unique case (state)
            ST_OFF: begin
               if (rx_enable_cmd_in && !rx_disable_cmd_in) begin
                  next_state = ST_HUNT;
               end
            end
            ST_HUNT: begin
               if (rx_disable_cmd_in) begin
                  next_state = ST_OFF;
               end else if (start_ok) begin
                  next_state = ST_RECV;
               end
            end
            ST_RECV: begin
               if (char_done) begin
                  next_state = (disable_pending || rx_disable_cmd_in) ?
                               ST_OFF : ST_HUNT;
               end
            end
            default: begin
               next_state = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // a disable during a character is held until its stop bit
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || rx_reset_cmd_in || next_state == ST_OFF) begin
         disable_pending <= 1'b0;
      end else if (rx_disable_cmd_in && in_recv) begin
         disable_pending <= 1'b1;
      end else if (rx_enable_cmd_in) begin
         disable_pending <= 1'b0;
      end
   end

   // ****************************************************************
   // start hunt and sample counters
   // ****************************************************************
   // counters only move on the tick, so a zero divisor freezes them
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || rx_reset_cmd_in || next_state == ST_OFF) begin
         low_seen <= 1'b0;
         os_cnt   <= '0;
      end else if (in_hunt && os_tick) begin
         if (!line_low) begin
            low_seen <= 1'b0;
            os_cnt   <= '0;
         end else if (!low_seen) begin
            low_seen <= 1'b1;
            os_cnt   <= '0;
         end else begin
            os_cnt   <= os_cnt + OS_CNT_W'(1);
         end
      end else if (in_recv && os_tick) begin
         if (char_done) begin
            low_seen <= 1'b0;
            os_cnt   <= '0;
         end else if (sample_now) begin
            os_cnt   <= SAMPLE_RELOAD;
         end else begin
            os_cnt   <= os_cnt + OS_CNT_W'(1);
         end
      end
   end

   // ****************************************************************
   // data shifter
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || rx_reset_cmd_in || !in_recv) begin
         bit_cnt <= '0;
      end else if (sample_now) begin
         bit_cnt <= bit_cnt + BIT_CNT_W'(1);
      end
   end

   // data arrives least significant bit first
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         shift   <= HOLD_RESET;
         par_bit <= 1'b0;
      end else begin
         if (data_slot) begin
            shift <= {rx_sync, shift[DATA_W-1:1]};
         end
         if (par_slot) begin
            par_bit <= rx_sync;
         end
      end
   end

   // ****************************************************************
   // holding register and status flags
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         rx_holding_reg_out <= HOLD_RESET;
      end else if (char_done) begin
         rx_holding_reg_out <= shift;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         rx_ready_flag_out      <= 1'b0;
         overrun_flag_out       <= 1'b0;
         parity_error_flag_out  <= 1'b0;
         framing_error_flag_out <= 1'b0;
      end else begin
         rx_ready_flag_out      <= next_ready;
         overrun_flag_out       <= next_ovr;
         parity_error_flag_out  <= next_parity_error_flag;
         framing_error_flag_out <= next_frame;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         rx_enabled_out <= 1'b0;
         rx_busy_out    <= 1'b0;
      end else begin
         rx_enabled_out <= (next_state != ST_OFF);
         rx_busy_out    <= (next_state == ST_RECV);
      end
   end

   // ****************************************************************
   // debug channel status
   // ****************************************************************
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         dcc_read_pending_out  <= 1'b0;
         dcc_write_pending_out <= 1'b0;
         dcc_irq_out           <= 1'b0;
      end else begin
         dcc_read_pending_out  <= dcc_sync[0];
         dcc_write_pending_out <= dcc_sync[1];
         dcc_irq_out           <= |(dcc_sync & dcc_irq_mask_in);
      end
   end

   // ****************************************************************
   // character stream buffer
   // ****************************************************************
   // a full buffer drops the character from the stream only; the holding
   // register still takes it, so software reads never depend on the sink
   char_fifo #(
      .WIDTH (STREAM_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_in    (sys_clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (char_done),
      .in_ready_out  (rx_fifo_ready_out),
      .in_data_in    ({stop_bad, par_bad, shift}),
      .out_valid_out (rx_stream_valid_out),
      .out_ready_in  (rx_stream_ready_in),
      .out_data_out  (rx_stream_data_out)
   );

endmodule

// *** verif/uart_rx_checker_asserts.sv ***
/* assertions on the ports of the debug uart receiver top.
   assumes a bind to that top and one clock domain. */
`timescale 1ns/1ps
module uart_rx_checker (
   input wire logic                          sys_clk_in,
   input wire logic                          resetn_in,
   input wire logic                          debug_rx_line_in,
   input wire logic [uart_rx_pkg::DIV_W-1:0] clock_divisor_in,
   input wire logic                          rx_enable_cmd_in,
   input wire logic                          rx_disable_cmd_in,
   input wire logic                          rx_reset_cmd_in,
   input wire logic                          status_reset_cmd_in,
   input wire logic                          rx_holding_read_in,
   input wire logic                          rx_ready_flag_out,
   input wire logic                          overrun_flag_out,
   input wire logic                          parity_error_flag_out,
   input wire logic                          framing_error_flag_out,
   input wire logic                          rx_enabled_out,
   input wire logic                          rx_busy_out
);
   import uart_rx_pkg::*;
   logic [19:0] low_cnt;
   logic [1:0]  zero_cnt;
   // ****************
   // helpers
   // ****************
   // low length in clocks, so start acceptance is judged without internals
   always_ff @(posedge sys_clk_in) begin
      low_cnt  <= debug_rx_line_in ? 20'h00000 : low_cnt + 20'h00001;
      zero_cnt <= (clock_divisor_in != 17'h00000) ? 2'h0 : zero_cnt + {1'b0, zero_cnt != 2'h3};
   end
   // ****************
   // properties
   // ****************
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   a_ready_at_end: assert property ($rose(rx_ready_flag_out) |-> $fell(rx_busy_out))
      else $error("ready rose outside a character end");
   a_read_clears: assert property (rx_holding_read_in && !rx_busy_out |=> !rx_ready_flag_out)
      else $error("ready not cleared by read");
   a_overrun_cause: assert property ($rose(overrun_flag_out) |->
      $fell(rx_busy_out) && $past(rx_ready_flag_out) && !$past(rx_holding_read_in))
      else $error("overrun without unread character");
   a_status_clear: assert property (status_reset_cmd_in && !rx_busy_out |=>
      !overrun_flag_out && !parity_error_flag_out && !framing_error_flag_out)
      else $error("flags not cleared by status reset");
   a_parity_at_end: assert property ($rose(parity_error_flag_out) |->
      $fell(rx_busy_out) && rx_ready_flag_out)
      else $error("parity flag not raised with ready");
   a_parity_sticky: assert property (parity_error_flag_out && !status_reset_cmd_in |=> parity_error_flag_out)
      else $error("parity flag dropped");
   a_framing_at_end: assert property ($rose(framing_error_flag_out) |->
      $fell(rx_busy_out) && rx_ready_flag_out)
      else $error("framing flag not raised with ready");
   a_reset_aborts: assert property (rx_reset_cmd_in |=> !rx_enabled_out && !rx_busy_out)
      else $error("receiver still active after reset command");
   a_enable_on: assert property (rx_enable_cmd_in && !rx_disable_cmd_in && !rx_reset_cmd_in
      |=> rx_enabled_out)
      else $error("receiver not enabled");
   a_zero_freezes: assert property (zero_cnt == 2'h3 && clock_divisor_in == 17'h00000
      && !rx_reset_cmd_in |=> $stable(rx_busy_out) && !$rose(rx_ready_flag_out))
      else $error("receiver moved with zero divisor");
   a_start_length: assert property ($rose(rx_busy_out) |-> low_cnt > 20'(7 * clock_divisor_in))
      else $error("start accepted on a short low");
   cover property ($rose(overrun_flag_out));
   cover property ($rose(parity_error_flag_out));
   cover property ($rose(framing_error_flag_out));
endmodule

// *** verif/serial_host.sv ***
/* model of the remote serial sender on the receive line.
   assumes divisor_in clocks per sampling tick and sixteen ticks a bit. */
`timescale 1ns/1ps
module serial_host (
   input  wire logic                          sys_clk_in,
   input  wire logic [uart_rx_pkg::DIV_W-1:0] divisor_in,
   output logic                               line_out
);
   import uart_rx_pkg::*;
   initial line_out = LINE_IDLE;
   task automatic drive(input logic v, input int ticks);
      line_out = v;
      repeat (ticks * divisor_in) @(posedge sys_clk_in);
      #1;
   endtask
   // low start, data lsb first, optional parity, stop, then idle
   // bad stop is cut short so its tail cannot pass for a new start
   task automatic send(input logic [7:0] d, input logic [2:0] par,
                       input logic flip, input logic stop);
      logic p;
      p = (par == PAR_EVEN) ? ^d : (par == PAR_ODD) ? ~^d : (par == PAR_MARK);
      drive(1'b0, 16);
      for (int i = 0; i < 8; i++) drive(d[i], 16);
      if (par < PAR_NONE) drive(p ^ flip, 16);
      drive(stop, 10);
      drive(LINE_IDLE, 10);
   endtask
   task automatic pulse_low(input int ticks);
      drive(1'b0, ticks);
      drive(LINE_IDLE, 10);
   endtask
endmodule

// *** verif/debug_uart_receiver_tb_top.sv ***
/* self-checking bench for the debug uart receiver.
   assumes host model and checker compiled first. */
`timescale 1ns/1ps
module debug_uart_receiver_tb_top;
   import uart_rx_pkg::*;
   localparam int BIT_CLKS = 32;
   logic                sys_clk_in = 1'b0;
   logic                resetn_in  = 1'b0;
   logic                line;
   logic                sink_rdy   = 1'b1;
   logic [DIV_W-1:0]    div        = 17'h00002;
   logic [DIV_W-1:0]    host_div   = 17'h00002;
   logic [2:0]          par        = PAR_NONE;
   logic [4:0]          cmd        = 5'h00;
   logic [1:0]          dcc        = 2'h0;
   logic [1:0]          mask       = 2'h0;
   logic [DATA_W-1:0]   hold;
   logic                rdy, ovr, pe, fe, en, busy, dr, dw, irq, frdy, sval;
   logic [STREAM_W-1:0] sdat;
   int                  mismatches = 0;
   int                  compares   = 0;
   always #10 sys_clk_in = ~sys_clk_in;
   serial_host host (.sys_clk_in(sys_clk_in), .divisor_in(host_div), .line_out(line));
   debug_uart_receiver dut (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .debug_rx_line_in(line),
      .clock_divisor_in(div), .parity_type_field_in(par),
      .rx_enable_cmd_in(cmd[0]), .rx_disable_cmd_in(cmd[1]), .rx_reset_cmd_in(cmd[2]),
      .status_reset_cmd_in(cmd[3]), .rx_holding_read_in(cmd[4]),
      .dcc_read_pending_in(dcc[0]), .dcc_write_pending_in(dcc[1]), .dcc_irq_mask_in(mask),
      .rx_stream_ready_in(sink_rdy), .rx_holding_reg_out(hold), .rx_ready_flag_out(rdy),
      .overrun_flag_out(ovr), .parity_error_flag_out(pe), .framing_error_flag_out(fe),
      .rx_enabled_out(en), .rx_busy_out(busy), .dcc_read_pending_out(dr),
      .dcc_write_pending_out(dw), .dcc_irq_out(irq), .rx_fifo_ready_out(frdy),
      .rx_stream_valid_out(sval), .rx_stream_data_out(sdat));
   // ****************
   // tasks
   // ****************
   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   // cmd bits: enable, disable, reset, status reset, holding read
   task automatic pulse(input logic [4:0] c);
      cmd = c;
      step();
      cmd = 5'h00;
      step();
   endtask
   task automatic flags(input logic [3:0] e);
      check("ready_ovr_par_frm", {rdy, ovr, pe, fe}, e);
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      step(16);
      resetn_in = 1'b1;
      step();
      check("holding", hold, 8'h00);
      check("en_busy_frdy_val_irq", {en, busy, frdy, sval, irq}, 5'h04);
      host.send(8'h5A, par, 1'b0, 1'b1);
      flags(4'h0);
      $display("test reset done");
      pulse(5'h01);
      check("enabled", en, 1'b1);
      for (int i = 0; i < 5; i++) begin
         par = 3'(i);
         host.send(8'h35 + 8'(i), par, 1'b0, 1'b1);
         flags(4'h8);
         check("holding", hold, 8'h35 + 8'(i));
         pulse(5'h10);
         flags(4'h0);
      end
      $display("test parity modes done");
      par = PAR_ODD;
      host.send(8'hC3, par, 1'b1, 1'b1);
      flags(4'hA);
      host.send(8'h3C, par, 1'b0, 1'b1);
      flags(4'hE);
      check("holding", hold, 8'h3C);
      pulse(5'h18);
      flags(4'h0);
      host.send(8'h81, par, 1'b0, 1'b0);
      flags(4'h9);
      host.send(8'h18, par, 1'b0, 1'b1);
      flags(4'hD);
      pulse(5'h18);
      $display("test errors done");
      host.pulse_low(6);
      check("busy", busy, 1'b0);
      flags(4'h0);
      fork
         host.send(8'hF0, par, 1'b0, 1'b1);
         begin
            step(4 * BIT_CLKS);
            pulse(5'h04);
            check("en_busy", {en, busy}, 2'b00);
         end
      join
      flags(4'h0);
      pulse(5'h01);
      fork
         host.send(8'h69, par, 1'b0, 1'b1);
         begin
            step(3 * BIT_CLKS);
            pulse(5'h02);
            check("enabled", en, 1'b1);
         end
      join
      flags(4'h8);
      check("holding", hold, 8'h69);
      check("enabled", en, 1'b0);
      pulse(5'h11);
      pulse(5'h02);
      check("enabled", en, 1'b0);
      $display("test control done");
      pulse(5'h01);
      div = 17'h00000;
      host.send(8'h42, par, 1'b0, 1'b1);
      flags(4'h0);
      div = 17'h00002;
      sink_rdy = 1'b0;
      for (int i = 0; i < 9; i++) begin
         host.send(8'(i + 1), par, 1'b0, 1'b1);
         pulse(5'h10);
      end
      check("fifo_rdy_valid", {frdy, sval}, 2'b01);
      sink_rdy = 1'b1;
      for (int i = 0; i < 8; i++) begin
         check("stream", sdat, 10'(i + 1));
         step();
      end
      check("stream_valid", sval, 1'b0);
      $display("test zero divisor and stream done");
      dcc = 2'h3;
      mask = 2'h1;
      step(4);
      check("dw_dr_irq", {dw, dr, irq}, 3'b111);
      mask = 2'h2;
      dcc = 2'h1;
      step(4);
      check("dw_dr_irq", {dw, dr, irq}, 3'b010);
      $display("test dcc done");
      results();
   end
   initial begin
      repeat (100000) @(posedge sys_clk_in);
      mismatches++;
      results();
   end
endmodule
bind debug_uart_receiver uart_rx_checker chk (.*);
